// ==== bench/resp_pace_regs_props.sv ====
// Purpose: concurrent checks on the register bank ports
// Assumes: one clock, asynchronous active-low reset, one-cycle ack
// Notes:   carrier half periods are judged only after a settled interval
`timescale 1ns/100ps
module resp_pace_regs_props
	import resp_pace_pkg::*;
(
	// clock and reset
	input wire logic        CORE_CLK,
	input wire logic        ARST_N,
	// wishbone
	input wire logic        WB_CYC_I,
	input wire logic        WB_STB_I,
	input wire logic        WB_WE_I,
	input wire logic        WB_ACK_O,
	input wire logic [7:0]  WB_ADR_I,
	input wire logic [3:0]  WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	input wire logic [31:0] WB_DAT_O,
	// respiration controls
	input wire logic        RESP_ENABLE,
	input wire logic        RESP_PERIODIC,
	input wire logic        RESP_CARRIER,
	input wire logic [1:0]  RESP_FREQ_CODE,
	// pace controls
	input wire logic        PULSE_WIDTH_FILTER_EN,
	input wire logic        VALIDATION_FILTER1_EN,
	input wire logic        VALIDATION_FILTER2_EN,
	input wire logic [1:0]  CHAN1_LEAD_SELECT,
	input wire logic [1:0]  CHAN2_LEAD_SELECT,
	input wire logic [1:0]  CHAN3_LEAD_SELECT,
	input wire logic [2:0]  PACE_DETECT_EN
);
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!ARST_N);

	// ---------------------------------------------------------------
	// carrier interval tracking
	// ---------------------------------------------------------------
	localparam logic [11:0] HP_TAB [8] = '{12'h37c, 12'h39d, 12'h3c1, 12'h3e8,
		12'h30d, 12'h36e, 12'h3d0, 12'h433};
	logic [11:0] run_q;
	logic        car_q, valid_q;
	logic [3:0]  cfg_q;
	wire  [3:0]  cfg = {RESP_ENABLE, RESP_PERIODIC, RESP_FREQ_CODE};
	wire         tog = RESP_CARRIER != car_q;

	// count samples of one carrier level, trust only unchanged settings
	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			run_q   <= 12'h0;
			car_q   <= 1'b0;
			valid_q <= 1'b0;
			cfg_q   <= 4'h0;
		end else begin
			car_q <= RESP_CARRIER;
			cfg_q <= cfg;
			run_q <= tog ? 12'h1 : run_q + 12'h1;
			if (cfg != cfg_q)
				valid_q <= 1'b0;
			else if (tog)
				valid_q <= 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// bus and field checks
	// ---------------------------------------------------------------
	sequence req_s; WB_CYC_I && WB_STB_I && !WB_ACK_O; endsequence
	sequence wr_resp_s;
		req_s ##0 (WB_WE_I && WB_ADR_I[7:2] == RESP_CTL_IDX && WB_SEL_I[0] && WB_SEL_I[2]);
	endsequence
	sequence wr_pace_s; req_s ##0 (WB_WE_I && WB_ADR_I[7:2] == PACE_CTL_IDX && WB_SEL_I[0]); endsequence
	sequence rd_pace_s; req_s ##0 (!WB_WE_I && WB_ADR_I[7:2] == PACE_CTL_IDX); endsequence

	chk_ack_next: assert property (req_s |=> WB_ACK_O) else $error("ack missing after request");
	chk_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack held too long");
	chk_dat_idle: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0) else $error("data outside ack");
	chk_resp_write: assert property (wr_resp_s |=> RESP_ENABLE == $past(WB_DAT_I[0])
		&& RESP_FREQ_CODE == $past(WB_DAT_I[2:1]) && RESP_PERIODIC == $past(WB_DAT_I[16]))
		else $error("respiration fields not written");
	chk_pace_write: assert property (wr_pace_s |=> PACE_DETECT_EN == $past(WB_DAT_I[2:0])
		&& CHAN1_LEAD_SELECT == $past(WB_DAT_I[4:3]) && CHAN2_LEAD_SELECT == $past(WB_DAT_I[6:5]))
		else $error("pace fields not written");
	chk_pace_reserved: assert property (rd_pace_s |=> WB_DAT_O[31:12] == 20'h0)
		else $error("reserved pace bits not zero");
	chk_ctrl_hold: assert property (!(WB_CYC_I && WB_STB_I && WB_WE_I)
		|=> $stable({PACE_DETECT_EN, CHAN3_LEAD_SELECT, RESP_ENABLE, PULSE_WIDTH_FILTER_EN}))
		else $error("control changed without a write");
	chk_carrier_idle: assert property (!RESP_ENABLE [*2] |-> !RESP_CARRIER)
		else $error("carrier active while disabled");
	chk_carrier_half: assert property (tog && valid_q && RESP_ENABLE && cfg == cfg_q
		|-> run_q == HP_TAB[{RESP_PERIODIC, RESP_FREQ_CODE}])
		else $error("carrier half period wrong");
endmodule : resp_pace_regs_props

// ==== bench/resp_pace_regs_test.sv ====
// Purpose: self-checking bench for the register bank
// Assumes: classic single Wishbone cycles, one-cycle ack
// Notes:   carrier periods are judged by the bound checker
`timescale 1ns/100ps
module resp_pace_regs_test import resp_pace_pkg::*;;
	logic        clk = 1'b0, arst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [3:0]  sel = 4'h0;
	logic [31:0] dat = 32'h0, dat_o, rdat, v;
	logic        ack, r_en, r_per, r_car, f_w, f_v2, f_v1;
	logic [1:0]  r_code, s1, s2, s3;
	logic [2:0]  p_en;
	int          num_errors = 0, cmp_count = 0, n_tog;
	logic        prev_car;
	wire  [31:0] pace_o = {20'h0, f_w, f_v2, f_v1, s3, s2, s1, p_en};
	wire  [31:0] resp_o = {15'h0, r_per, 13'h0, r_code, r_en};

	always #5 clk = ~clk;

	resp_pace_regs u_resp_pace_regs (.CORE_CLK(clk), .ARST_N(arst_n), .WB_CYC_I(cyc),
		.WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat),
		.WB_DAT_O(dat_o), .WB_ACK_O(ack), .RESP_ENABLE(r_en), .RESP_FREQ_CODE(r_code),
		.RESP_PERIODIC(r_per), .RESP_CARRIER(r_car), .PACE_DETECT_EN(p_en),
		.CHAN1_LEAD_SELECT(s1), .CHAN2_LEAD_SELECT(s2), .CHAN3_LEAD_SELECT(s3),
		.PULSE_WIDTH_FILTER_EN(f_w), .VALIDATION_FILTER1_EN(f_v1), .VALIDATION_FILTER2_EN(f_v2));

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// one classic cycle, held until ack is sampled high
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		cyc <= 1'b1;
		stb <= 1'b1;
		we  <= w;
		adr <= a;
		dat <= d;
		sel <= s;
		do begin
			@(posedge clk);
		end while (ack !== 1'b1);
		rdat = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask : bus

	task rd(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0, 4'hf);
		chk(rdat, exp);
	endtask : rd

	task end_sim;
		$display("errors %0d, comparisons %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : end_sim

	// watchdog
	initial begin
		#1_000_000;
		num_errors++;
		end_sim();
	end

	// main sequence
	initial begin
		repeat (12) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		chk(pace_o, 32'hf88);
		chk(resp_o, 32'h0);
		rd(8'h0c, 32'h0);
		rd(8'h10, 32'hf88);
		bus(1'b1, 8'h10, 32'hffffffff, 4'hf);
		rd(8'h10, 32'hfff);
		bus(1'b1, 8'h10, 32'h0, 4'hf);
		chk(pace_o, 32'h0);
		for (int c = 0; c < 4; c++) begin
			v = (c << 7) | (c << 5) | (c << 3) | (1 << (c % 3));
			bus(1'b1, 8'h10, v, 4'hf);
			chk(pace_o, v);
		end
		bus(1'b1, 8'h10, 32'h00000f00, 4'h2);
		chk(pace_o, 32'hff9);
		bus(1'b1, 8'h20, 32'hffffffff, 4'hf);
		rd(8'h20, 32'h0);
		rd(8'h10, 32'hff9);
		bus(1'b1, 8'h0c, 32'hffffffff, 4'hf);
		rd(8'h0c, 32'h1ffff);
		for (int i = 0; i < 8; i++) begin
			v = {15'h0, i[2], 13'h0, i[1:0], 1'b1};
			bus(1'b1, 8'h0c, v, 4'hf);
			chk(resp_o, v);
			n_tog = 0;
			repeat (3300) begin
				prev_car = r_car;
				@(posedge clk);
				if (r_car !== prev_car)
					n_tog++;
			end
			chk({31'h0, n_tog >= 2}, 32'h1);
		end
		bus(1'b1, 8'h0c, 32'h0, 4'hf);
		repeat (2000) @(posedge clk);
		chk({31'h0, r_car}, 32'h0);
		bus(1'b1, 8'h0c, 32'h00010007, 4'hf);
		arst_n <= 1'b0;
		@(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		chk(resp_o, 32'h0);
		rd(8'h10, 32'hf88);
		end_sim();
	end
endmodule : resp_pace_regs_test

bind resp_pace_regs resp_pace_regs_props u_resp_pace_regs_props (.CORE_CLK, .ARST_N, .WB_CYC_I,
	.WB_STB_I, .WB_WE_I, .WB_ACK_O, .WB_ADR_I, .WB_SEL_I, .WB_DAT_I, .WB_DAT_O, .RESP_ENABLE,
	.RESP_PERIODIC, .RESP_CARRIER, .PULSE_WIDTH_FILTER_EN, .VALIDATION_FILTER1_EN,
	.VALIDATION_FILTER2_EN, .RESP_FREQ_CODE, .CHAN1_LEAD_SELECT, .CHAN2_LEAD_SELECT,
	.CHAN3_LEAD_SELECT, .PACE_DETECT_EN);

// ==== hdl/carrier_if.sv ====
// Purpose: carrier settings from the register bank to the carrier generator
// Assumes: one clock domain
// Notes:   carrier output comes back from the generator flop
`timescale 1ns/100ps
interface carrier_if;
	logic [1:0] freq_code;
	logic       periodic;
	logic       enable;
	logic       carrier;

	modport ctrl (output freq_code, output periodic, output enable, input carrier);
	modport gen  (input freq_code, input periodic, input enable, output carrier);
endinterface : carrier_if

// ==== hdl/resp_carrier_gen.sv ====
// Purpose: respiration carrier square wave from the frequency code
// Assumes: settings come from registers on the same clock
// Notes:   idle low while respiration is disabled
`timescale 1ns/100ps
module resp_carrier_gen
	import resp_pace_pkg::*;
(
	// clock and reset
	input  wire logic clk,
	input  wire logic arst_n,
	// settings and carrier
	carrier_if.gen    cif
);

	// ---------------------------------------------------------------
	// half period lookup
	// ---------------------------------------------------------------
	function automatic logic [HP_W-1:0] half_period(input logic [1:0] code, input logic per);
		logic [HP_W-1:0] hp;
		hp = HP_N0;
		unique case ({per, code})
			3'h0: hp = HP_N0;
			3'h1: hp = HP_N1;
			3'h2: hp = HP_N2;
			3'h3: hp = HP_N3;
			3'h4: hp = HP_P0;
			3'h5: hp = HP_P1;
			3'h6: hp = HP_P2;
			3'h7: hp = HP_P3;
		endcase
		return hp;
	endfunction : half_period

	// elaboration check: a zero half period cannot be counted
	if (HP_P0 < HP_W'(1) || HP_N0 < HP_W'(1)) begin : g_hp_check
		$error("carrier half period below one clock cycle");
	end

	logic [HP_W-1:0] cnt_q;
	logic [HP_W-1:0] cnt_d;
	logic            car_q;
	logic            car_d;
	wire  [HP_W-1:0] hp_now = half_period(cif.freq_code, cif.periodic);
	wire             wrap   = (cnt_q >= hp_now - HP_W'(1));

	// count half periods, stopped and low when disabled
	assign cnt_d = !cif.enable ? '0 : (wrap ? '0 : cnt_q + HP_W'(1));
	assign car_d = !cif.enable ? 1'b0 : (wrap ? ~car_q : car_q);
	assign cif.carrier = car_q;

	// counter and carrier flops
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_q <= '0;
			car_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			car_q <= car_d;
		end
	end

endmodule : resp_carrier_gen

// ==== hdl/resp_pace_pkg.sv ====
// Purpose: shared constants for the respiration and pace control register bank
// Assumes: 100 MHz core clock, 32-bit classic Wishbone register port
// Notes:   register offsets are word indices; byte address is four times the index
package resp_pace_pkg;

	// ---------------------------------------------------------------
	// register map
	// ---------------------------------------------------------------
	localparam logic [5:0]  RESP_CTL_IDX      = 6'h03;
	localparam logic [5:0]  PACE_CTL_IDX      = 6'h04;
	localparam int          REG_W             = 24;
	localparam logic [23:0] RESP_CTL_RST      = 24'h000000;
	localparam logic [23:0] PACE_CTL_RST      = 24'h000f88;
	localparam logic [23:0] RESP_CTL_WMASK    = 24'h01ffff; // bits 23:17 reserved
	localparam logic [23:0] PACE_CTL_WMASK    = 24'h000fff; // bits 23:12 reserved

	// ---------------------------------------------------------------
	// respiration field positions
	// ---------------------------------------------------------------
	localparam int RESP_EN_BIT        = 0;
	localparam int RESP_FREQ_LSB      = 1;
	localparam int RESP_PERIODIC_BIT  = 16;

	// ---------------------------------------------------------------
	// pace field positions
	// ---------------------------------------------------------------
	localparam int PACE_EN_LSB        = 0;
	localparam int CHAN1_SEL_LSB      = 3;
	localparam int CHAN2_SEL_LSB      = 5;
	localparam int CHAN3_SEL_LSB      = 7;
	localparam int VAL_FILT1_BIT      = 9;
	localparam int VAL_FILT2_BIT      = 10;
	localparam int WIDTH_FILT_BIT     = 11;

	// ---------------------------------------------------------------
	// lead selector codes
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		LEAD_I   = 2'h0,
		LEAD_II  = 2'h1,
		LEAD_III = 2'h2,
		LEAD_AVF = 2'h3
	} lead_sel_t;

	// ---------------------------------------------------------------
	// carrier timing: frequencies in Hz, half periods in clock cycles
	// ---------------------------------------------------------------
	localparam int CLK_HZ             = 100_000_000;
	localparam int HP_W               = 12;
	localparam int FREQ_N0_HZ         = 56000;
	localparam int FREQ_N1_HZ         = 54000;
	localparam int FREQ_N2_HZ         = 52000;
	localparam int FREQ_N3_HZ         = 50000;
	localparam int FREQ_P0_HZ         = 64000;
	localparam int FREQ_P1_HZ         = 56900;
	localparam int FREQ_P2_HZ         = 51200;
	localparam int FREQ_P3_HZ         = 46500;
	localparam logic [HP_W-1:0] HP_N0 = HP_W'(CLK_HZ / (2 * FREQ_N0_HZ));
	localparam logic [HP_W-1:0] HP_N1 = HP_W'(CLK_HZ / (2 * FREQ_N1_HZ));
	localparam logic [HP_W-1:0] HP_N2 = HP_W'(CLK_HZ / (2 * FREQ_N2_HZ));
	localparam logic [HP_W-1:0] HP_N3 = HP_W'(CLK_HZ / (2 * FREQ_N3_HZ));
	localparam logic [HP_W-1:0] HP_P0 = HP_W'(CLK_HZ / (2 * FREQ_P0_HZ));
	localparam logic [HP_W-1:0] HP_P1 = HP_W'(CLK_HZ / (2 * FREQ_P1_HZ));
	localparam logic [HP_W-1:0] HP_P2 = HP_W'(CLK_HZ / (2 * FREQ_P2_HZ));
	localparam logic [HP_W-1:0] HP_P3 = HP_W'(CLK_HZ / (2 * FREQ_P3_HZ));

endpackage : resp_pace_pkg

// ==== hdl/resp_pace_regs.sv ====
// Purpose: respiration and pace control register bank on classic Wishbone
// Assumes: single clock, asynchronous active-low reset, 32-bit data
// Notes:   one-cycle ack; unmapped addresses ack with zero data
//
// Contract
// - carrier frequency from code and periodic mode
// - respiration runs only while enable bit set
// - respiration control resets to all zero
// - bit 11 switches pulse-width filter, resets one
// - bit 10 switches validation filter two, resets one
// - bit 9 switches validation filter one, resets one
// - three two-bit lead selectors, reset 11,00,01
// - bits 2..0 enable channels three..one, reset zero
// - bit 16 selects periodic carrier waveform
// - pace control at index 4, reset 0x000f88
`timescale 1ns/100ps
module resp_pace_regs
	import resp_pace_pkg::*;
(
	// clock and reset
	input  wire logic        CORE_CLK,
	input  wire logic        ARST_N,
	// wishbone slave
	input  wire logic        WB_CYC_I,
	input  wire logic        WB_STB_I,
	input  wire logic        WB_WE_I,
	input  wire logic [7:0]  WB_ADR_I,
	input  wire logic [3:0]  WB_SEL_I,
	input  wire logic [31:0] WB_DAT_I,
	output logic      [31:0] WB_DAT_O,
	output logic             WB_ACK_O,
	// respiration controls
	output logic             RESP_ENABLE,
	output logic      [1:0]  RESP_FREQ_CODE,
	output logic             RESP_PERIODIC,
	output logic             RESP_CARRIER,
	// pace controls
	output logic      [2:0]  PACE_DETECT_EN,
	output logic      [1:0]  CHAN1_LEAD_SELECT,
	output logic      [1:0]  CHAN2_LEAD_SELECT,
	output logic      [1:0]  CHAN3_LEAD_SELECT,
	output logic             PULSE_WIDTH_FILTER_EN,
	output logic             VALIDATION_FILTER1_EN,
	output logic             VALIDATION_FILTER2_EN
);

	// ---------------------------------------------------------------
	// bus decode
	// ---------------------------------------------------------------
	function automatic logic [23:0] merge(input logic [23:0] old, input logic [31:0] wdat,
		input logic [3:0] sel, input logic [23:0] wmask);
		logic [23:0] res;
		res = old;
		for (int b = 0; b < 3; b++) begin
			if (sel[b])
				res[b*8 +: 8] = wdat[b*8 +: 8];
		end
		return res & wmask;
	endfunction : merge

	logic [23:0] resp_ctl_q;
	logic [23:0] pace_ctl_q;
	logic [23:0] resp_ctl_d;
	logic [23:0] pace_ctl_d;
	logic        ack_q;
	logic [31:0] rdat_q;
	logic [31:0] rdat_d;

	wire       req       = WB_CYC_I & WB_STB_I & ~ack_q;
	wire [5:0] idx       = WB_ADR_I[7:2];
	wire       hit_resp  = (idx == RESP_CTL_IDX);
	wire       hit_pace  = (idx == PACE_CTL_IDX);
	wire       wr_resp   = req & WB_WE_I & hit_resp;
	wire       wr_pace   = req & WB_WE_I & hit_pace;

	// next register values; reserved bits forced to zero
	assign resp_ctl_d = wr_resp ? merge(resp_ctl_q, WB_DAT_I, WB_SEL_I, RESP_CTL_WMASK)
		: resp_ctl_q;
	assign pace_ctl_d = wr_pace ? merge(pace_ctl_q, WB_DAT_I, WB_SEL_I, PACE_CTL_WMASK)
		: pace_ctl_q;

	// read mux, zero for unmapped or write
	assign rdat_d = !(req & ~WB_WE_I) ? 32'h0000_0000 :
		hit_resp ? {8'h00, resp_ctl_q} :
		hit_pace ? {8'h00, pace_ctl_q} : 32'h0000_0000;

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			resp_ctl_q <= RESP_CTL_RST;
			pace_ctl_q <= PACE_CTL_RST;
		end else begin
			resp_ctl_q <= resp_ctl_d;
			pace_ctl_q <= pace_ctl_d;
		end
	end

	// bus answer, one cycle ack
	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			ack_q  <= 1'b0;
			rdat_q <= 32'h0000_0000;
		end else begin
			ack_q  <= req;
			rdat_q <= rdat_d;
		end
	end

	assign WB_ACK_O = ack_q;
	assign WB_DAT_O = rdat_q;

	// ---------------------------------------------------------------
	// field outputs straight from register flops
	// ---------------------------------------------------------------
	assign RESP_ENABLE           = resp_ctl_q[RESP_EN_BIT];
	assign RESP_FREQ_CODE        = resp_ctl_q[RESP_FREQ_LSB +: 2];
	assign RESP_PERIODIC         = resp_ctl_q[RESP_PERIODIC_BIT];
	assign PACE_DETECT_EN        = pace_ctl_q[PACE_EN_LSB +: 3];
	assign CHAN1_LEAD_SELECT     = pace_ctl_q[CHAN1_SEL_LSB +: 2];
	assign CHAN2_LEAD_SELECT     = pace_ctl_q[CHAN2_SEL_LSB +: 2];
	assign CHAN3_LEAD_SELECT     = pace_ctl_q[CHAN3_SEL_LSB +: 2];
	assign PULSE_WIDTH_FILTER_EN = pace_ctl_q[WIDTH_FILT_BIT];
	assign VALIDATION_FILTER2_EN = pace_ctl_q[VAL_FILT2_BIT];
	assign VALIDATION_FILTER1_EN = pace_ctl_q[VAL_FILT1_BIT];

	// ---------------------------------------------------------------
	// respiration carrier
	// ---------------------------------------------------------------
	carrier_if cif ();

	assign cif.freq_code = resp_ctl_q[RESP_FREQ_LSB +: 2];
	assign cif.periodic  = resp_ctl_q[RESP_PERIODIC_BIT];
	assign cif.enable    = resp_ctl_q[RESP_EN_BIT];
	assign RESP_CARRIER  = cif.carrier;

	resp_carrier_gen u_carrier (
		.clk    (CORE_CLK),
		.arst_n (ARST_N),
		.cif    (cif)
	);

endmodule : resp_pace_regs
